// ### logic/gpio_port.sv
// Operation
// - eight pins, each input or output
// - direction one floats pin, zero drives latch
// - read gives pins, write goes to latch
// - writes are read-modify-write of pin levels
// - clearing option bit 7 enables pull-ups
// - output pins never get a pull-up
// - pull-ups disabled after power-on reset
// - change detect on upper input pins only
// - compare against value captured at last read or write
// - ORed mismatches set change flag, bit 0
// - change flag can wake from sleep
// - port access ends mismatch; software clears flag
// - persisting mismatch keeps setting the flag
// - change at read phase two may be missed
// - writes end cycle, reads sample at start
// - rst sets all direction bits; power-on alone does not
`default_nettype none
module gpio_port (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           por,
  // port data access from the core
  input  wire logic                           data_rd,
  input  wire logic                           data_wr,
  input  wire logic [port_pkg::PORT_WIDTH-1:0] data_wdata,
  output logic      [port_pkg::PORT_WIDTH-1:0] data_rdata,
  // direction register access
  input  wire logic                           dir_wr,
  input  wire logic [port_pkg::PORT_WIDTH-1:0] dir_wdata,
  output logic      [port_pkg::PORT_WIDTH-1:0] second_port_direction,
  // option and irq control bits
  input  wire logic                           option_wr,
  input  wire logic [7:0]                     option_wdata,
  output logic                                pullup_disable_n,
  input  wire logic                           flag_clr,
  output logic                                pin_change_irq_flag,
  input  wire logic                           sleeping,
  output logic                                wake,
  output logic      [1:0]                     phase,
  // pins
  input  wire logic [port_pkg::PORT_WIDTH-1:0] pin_in,
  output logic      [port_pkg::PORT_WIDTH-1:0] pin_out,
  output logic      [port_pkg::PORT_WIDTH-1:0] pin_oe,
  output logic      [port_pkg::PORT_WIDTH-1:0] pullup_en
);
  import port_pkg::*;

  ////////////////////////////////////////////////////////////////
  // declarations
  logic [PORT_WIDTH-1:0]   second_port_data;  // output latch
  logic [PORT_WIDTH-1:0]   pins_sync;         // synchronised pin levels
  logic [PORT_WIDTH-1:0]   sample_reg;        // pins taken at cycle start
  logic [CHANGE_WIDTH-1:0] old_reg;           // upper values at last read or write
  logic [CHANGE_WIDTH-1:0] mismatch;          // per-pin change compare
  logic                    any_change;        // ORed mismatch
  logic                    rd_pend_reg;       // read requested this cycle
  logic                    wr_pend_reg;       // write pending to cycle end
  logic [PORT_WIDTH-1:0]   wval_reg;          // value held for the write

  sync_if #(.W(PORT_WIDTH)) sif ();
  assign sif.raw   = pin_in;
  assign pins_sync = sif.sync;

  ////////////////////////////////////////////////////////////////
  // input synchroniser
  pin_sync u_sync (
    .clk (clk),
    .rst (rst),
    .bus (sif)
  );

  ////////////////////////////////////////////////////////////////
  // four-phase instruction cycle counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= PHASE_ONE;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // requests are latched and served on their phases
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pend_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wval_reg    <= 8'h00;
    end else begin
      // read request consumed at phase two
      if (data_rd) begin
        rd_pend_reg <= 1'b1;
      end else if (phase == PHASE_TWO) begin
        rd_pend_reg <= 1'b0;
      end
      // write request held until phase four
      if (data_wr) begin
        wr_pend_reg <= 1'b1;
        wval_reg    <= data_wdata;
      end else if (phase == PHASE_FOUR) begin
        wr_pend_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // pins sampled at the start of each cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_reg <= 8'h00;
      data_rdata <= 8'h00;
    end else if (phase == PHASE_ONE) begin
      sample_reg <= pins_sync;
      data_rdata <= pins_sync;
    end
  end

  ////////////////////////////////////////////////////////////////
  // output latch: write at end of cycle, read-modify-write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      second_port_data <= LATCH_RESET;
    end else if (wr_pend_reg && phase == PHASE_FOUR) begin
      // input pins take sampled level, outputs take the written bit
      second_port_data <= (wval_reg & ~second_port_direction)
                        | (sample_reg & second_port_direction);
    end
  end

  ////////////////////////////////////////////////////////////////
  // direction register, all inputs after rst (power-on alone leaves it)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      second_port_direction <= DIRECTION_RESET;
    end else if (dir_wr) begin
      second_port_direction <= dir_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pull-up control bit, disabled after reset and after power-on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pullup_disable_n <= PULLUP_DIS_RST;
    end else if (por) begin
      pullup_disable_n <= PULLUP_DIS_RST;
    end else if (option_wr) begin
      pullup_disable_n <= option_wdata[PULLUP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drivers and pull-ups
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out   <= LATCH_RESET;
      pin_oe    <= 8'h00;
      pullup_en <= 8'h00;
    end else begin
      pin_out   <= second_port_data;
      pin_oe    <= ~second_port_direction;
      pullup_en <= {PORT_WIDTH{~pullup_disable_n}} & second_port_direction;
    end
  end

  ////////////////////////////////////////////////////////////////
  // change compare on upper input pins
  always_comb begin
    mismatch = (pins_sync[CHANGE_LO +: CHANGE_WIDTH] ^ old_reg)
             & second_port_direction[CHANGE_LO +: CHANGE_WIDTH];
    any_change = |mismatch;
  end

  ////////////////////////////////////////////////////////////////
  // capture refreshed by any port access; read at phase two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      old_reg <= 4'h0;
    end else if ((rd_pend_reg && phase == PHASE_TWO) || (wr_pend_reg && phase == PHASE_FOUR)) begin
      // a change landing on this edge is absorbed into the capture
      old_reg <= pins_sync[CHANGE_LO +: CHANGE_WIDTH];
    end
  end

  ////////////////////////////////////////////////////////////////
  // change flag: set beats clear, re-set while mismatch lasts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_change_irq_flag <= 1'b0;
    end else if (any_change) begin
      pin_change_irq_flag <= 1'b1;
    end else if (flag_clr) begin
      pin_change_irq_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // wake request while asleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake <= 1'b0;
    end else begin
      wake <= sleeping && (pin_change_irq_flag || any_change);
    end
  end

  ////////////////////////////////////////////////////////////////
  // assertions
  property p_dir_reset;
    @(posedge clk) $fell(rst) |-> second_port_direction == 8'hff;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not all ones after reset");

  property p_drive;
    @(posedge clk) disable iff (rst) 1'b1 |=> pin_oe == ~$past(second_port_direction);
  endproperty
  a_drive: assert property (p_drive) else $error("driver enable wrong");

  property p_pull_out;
    @(posedge clk) disable iff (rst) 1'b1 |=> (pullup_en & pin_oe) == 8'h00;
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull-up on output pin");

  property p_pull_on;
    @(posedge clk) disable iff (rst)
      (!pullup_disable_n && second_port_direction == 8'hff) ##1 $stable(second_port_direction)
      |-> pullup_en == 8'hff;
  endproperty
  a_pull_on: assert property (p_pull_on) else $error("pull-ups not enabled");

  property p_flag_set;
    @(posedge clk) disable iff (rst) any_change |=> pin_change_irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("change flag not set");

  property p_flag_hold;
    @(posedge clk) disable iff (rst) (any_change && flag_clr) |=> pin_change_irq_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("clear beat persisting mismatch");

  property p_wr_latch;
    @(posedge clk) disable iff (rst)
      (wr_pend_reg && phase == PHASE_FOUR && !dir_wr && !data_wr)
      |=> second_port_data == (($past(wval_reg) & ~second_port_direction)
                              | ($past(sample_reg) & second_port_direction));
  endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("latch not read-modify-write");

  property p_upper_out;
    @(posedge clk) disable iff (rst)
      second_port_direction[7:4] == 4'h0 |-> !any_change;
  endproperty
  a_upper_out: assert property (p_upper_out) else $error("output pin caused change");

  property p_read_ends;
    @(posedge clk) disable iff (rst)
      (rd_pend_reg && phase == PHASE_TWO) ##1 $stable(pins_sync) ##0 $stable(second_port_direction)
      |-> !any_change;
  endproperty
  a_read_ends: assert property (p_read_ends) else $error("read did not end mismatch");

  property p_sample;
    @(posedge clk) disable iff (rst) phase == PHASE_ONE |=> data_rdata == $past(pins_sync);
  endproperty
  a_sample: assert property (p_sample) else $error("read not sampled at cycle start");

  property p_wake;
    @(posedge clk) disable iff (rst) (sleeping && pin_change_irq_flag) |=> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on change");

  // no wake request is held once the core is awake
  property p_wake_off;
    @(posedge clk) disable iff (rst) !sleeping |=> !wake;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake while awake");

  // the phase counter steps once per clock, wrapping after phase four
  property p_phase_step;
    @(posedge clk) disable iff (rst) 1'b1 |=> phase == $past(phase) + 2'h1;
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase counter skipped");

  // the latch only moves on the edge that ends an instruction
  property p_latch_hold;
    @(posedge clk) disable iff (rst) phase != PHASE_FOUR |=> $stable(second_port_data);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved mid-cycle");

  // a direction write lands on the next edge
  property p_dir_load;
    @(posedge clk) disable iff (rst) dir_wr |=> second_port_direction == $past(dir_wdata);
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction write lost");

  // power-on forces the pull-ups off again
  property p_por_pull;
    @(posedge clk) disable iff (rst) por |=> pullup_disable_n;
  endproperty
  a_por_pull: assert property (p_por_pull) else $error("pull-ups left on after power-on");

  // a clear with no mismatch present drops the flag
  property p_flag_clear;
    @(posedge clk) disable iff (rst) (flag_clr && !any_change) |=> !pin_change_irq_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");

  // a read captures the upper pin levels at phase two
  property p_rd_capture;
    @(posedge clk) disable iff (rst)
      (rd_pend_reg && phase == PHASE_TWO) |=> old_reg == $past(pins_sync[CHANGE_LO +: CHANGE_WIDTH]);
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("read did not refresh capture");
endmodule : gpio_port
`default_nettype wire

// ### shared/port_pkg.sv
`default_nettype none
package port_pkg;
  // port geometry
  localparam int unsigned PORT_WIDTH      = 8;
  localparam int unsigned CHANGE_LO       = 4;
  localparam int unsigned CHANGE_WIDTH    = 4;
  // reset values
  localparam logic [7:0]  DIRECTION_RESET = 8'hff;
  localparam logic [7:0]  LATCH_RESET     = 8'h00;
  localparam logic        PULLUP_DIS_RST  = 1'b1;
  // field positions in the control registers
  localparam int unsigned PULLUP_BIT      = 7;
  localparam int unsigned CHANGE_FLAG_BIT = 0;
  // instruction cycle: four clock phases
  localparam int unsigned PHASES          = 4;
  localparam logic [1:0]  PHASE_ONE       = 2'h0;
  localparam logic [1:0]  PHASE_TWO       = 2'h1;
  localparam logic [1:0]  PHASE_FOUR      = 2'h3;
endpackage : port_pkg
`default_nettype wire

// ### shared/sync_if.sv
`default_nettype none
// raw pins in, synchronised levels out
interface sync_if #(parameter int unsigned W = 8);
  logic [W-1:0] raw;   // asynchronous pin levels
  logic [W-1:0] sync;  // levels after two flops
  modport owner (output raw, input sync);
  modport stage (input raw, output sync);
endinterface : sync_if
`default_nettype wire

// ### logic/pin_sync.sv
`default_nettype none
// two-flop synchroniser for a group of pins
module pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pins
  sync_if.stage     bus
);
  import port_pkg::*;
  logic [PORT_WIDTH-1:0] first_reg;   // metastable stage, read only by second
  logic [PORT_WIDTH-1:0] second_reg;  // stable stage

  ////////////////////////////////////////////////////////////////
  // both stages reset to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_reg  <= 8'h00;
      second_reg <= 8'h00;
    end else begin
      first_reg  <= bus.raw;
      second_reg <= first_reg;
    end
  end
  assign bus.sync = second_reg;
endmodule : pin_sync
`default_nettype wire

// ### bench/pin_model.sv
`default_nettype none
// board side of the port: keypad drivers, weak pull-ups, floating lines
module pin_model (
  // clock
  input  wire logic       clk,
  // port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  // bench control of the board
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_reg = 8'h5a; // level of a line nobody holds
  // a floating line wanders every cycle, so it never looks stable
  always @(posedge clk) float_reg <= ~float_reg;
  // a driving pin wins; the board never fights it
  always_comb begin
    pin_in = pin_out & pin_oe;
    pin_in = pin_in | (ext_val & ext_en & ~pin_oe);
    pin_in = pin_in | (pullup_en & ~ext_en & ~pin_oe);
    pin_in = pin_in | (float_reg & ~pullup_en & ~ext_en & ~pin_oe);
  end
endmodule : pin_model
`default_nettype wire

// ### bench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import port_pkg::*;
  // stimulus and observation
  logic       clk, rst, por, data_rd, data_wr, dir_wr, option_wr, flag_clr, sleeping;
  logic [7:0] data_wdata, dir_wdata, option_wdata, pin_in, ext_en, ext_val;
  logic [7:0] data_rdata, second_port_direction, pin_out, pin_oe, pullup_en;
  logic       pullup_disable_n, pin_change_irq_flag, wake;
  logic [1:0] phase;
  int         num_errors, samples_checked;
  logic [7:0] lfsr_reg, d, v, e, latch; // random draws and expected latch
  gpio_port dut (.clk(clk), .rst(rst), .por(por), .data_rd(data_rd), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rdata(data_rdata), .dir_wr(dir_wr), .dir_wdata(dir_wdata),
    .second_port_direction(second_port_direction), .option_wr(option_wr), .option_wdata(option_wdata),
    .pullup_disable_n(pullup_disable_n), .flag_clr(flag_clr), .pin_change_irq_flag(pin_change_irq_flag),
    .sleeping(sleeping), .wake(wake), .phase(phase), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en));
  pin_model board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // random source
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  // pin levels: outputs show the latch, inputs show the board
  function automatic logic [7:0] exp_pins(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] ext);
    return (lat & ~dir) | (ext & dir);
  endfunction : exp_pins
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // wait n edges, then move off the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // one-cycle strobe in the first phase of an instruction
  task automatic pulse(ref logic s);
    for (int i = 0; i < 8 && phase !== PHASE_ONE; i++) step(1);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse
  // counts and verdict
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // watchdog
  initial begin
    step(20000);
    num_errors++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  // main sequence
  initial begin
    {rst, por} = 2'h3;
    {data_rd, data_wr, dir_wr, option_wr, flag_clr, sleeping} = 6'h00;
    {data_wdata, dir_wdata, option_wdata, ext_val} = 32'h0;
    ext_en = 8'hff;
    lfsr_reg = 8'h18;
    step(8);
    {rst, por} = 2'h0;
    check(second_port_direction, DIRECTION_RESET, "dir");
    check(pin_oe, 8'h00, "oe");
    check({7'h00, pullup_disable_n}, 8'h01, "pu_dis");
    check(pullup_en, 8'h00, "pu");
    $display("test reset done");
    // random direction, data and board levels
    for (int k = 0; k < 24; k++) begin
      lfsr_reg = lfsr_next(lfsr_reg);
      d = (k == 0) ? 8'h00 : lfsr_reg;
      lfsr_reg = lfsr_next(lfsr_reg);
      v = lfsr_reg;
      lfsr_reg = lfsr_next(lfsr_reg);
      e = (k == 1) ? 8'hff : lfsr_reg;
      ext_val = e;
      dir_wdata = d;
      pulse(dir_wr);
      step(8);
      data_wdata = v;
      pulse(data_wr);
      step(12);
      latch = (v & ~d) | (e & d);
      check(pin_oe, ~d, "oe");
      check(second_port_direction, d, "dir");
      check(data_rdata, exp_pins(d, latch, e), "rd");
      dir_wdata = 8'h00;
      pulse(dir_wr);
      step(12);
      check(pin_out, latch, "latch");
    end
    $display("test random done");
    // pull-ups on with a released board
    ext_en = 8'h00;
    dir_wdata = 8'h0f;
    pulse(dir_wr);
    option_wdata = 8'h7f;
    pulse(option_wr);
    step(12);
    check({7'h00, pullup_disable_n}, 8'h00, "pu_dis");
    check(pullup_en, 8'h0f, "pu");
    check(data_rdata & 8'h0f, 8'h0f, "pulled");
    // all eight pins as inputs: every pull-up on together
    dir_wdata = 8'hff;
    pulse(dir_wr);
    step(12);
    check(pullup_en, 8'hff, "pu");
    check(data_rdata, 8'hff, "pulled");
    por = 1'b1;
    step(1);
    por = 1'b0;
    step(2);
    check({7'h00, pullup_disable_n}, 8'h01, "pu_dis");
    $display("test pullup done");
    // change detection; software waits instead of polling
    ext_en = 8'hff;
    ext_val = 8'h00;
    dir_wdata = 8'hff;
    pulse(dir_wr);
    step(12);
    pulse(data_rd);
    step(8);
    pulse(flag_clr);
    step(4);
    check({7'h00, pin_change_irq_flag}, 8'h00, "flag");
    ext_val = 8'h0f;
    step(12);
    check({7'h00, pin_change_irq_flag}, 8'h00, "flag");
    ext_val = 8'h1f;
    step(12);
    check({7'h00, pin_change_irq_flag}, 8'h01, "flag");
    sleeping = 1'b1;
    step(4);
    check({7'h00, wake}, 8'h01, "wake");
    sleeping = 1'b0;
    pulse(flag_clr);
    step(4);
    check({7'h00, pin_change_irq_flag}, 8'h01, "flag");
    pulse(data_rd);
    step(8);
    pulse(flag_clr);
    step(8);
    check({7'h00, pin_change_irq_flag}, 8'h00, "flag");
    $display("test change done");
    // reset again in mid-run
    dir_wdata = 8'h00;
    pulse(dir_wr);
    step(4);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    check(second_port_direction, DIRECTION_RESET, "dir");
    check(pin_oe, 8'h00, "oe");
    $display("test rereset done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
